// ===== core/asps_pkg.sv
// Constants, state codes and carrier structs for the sleep-state sequencer.
package asps_pkg;

  // Clock rate and documented times; cycle counts derive from them.
  localparam int CLK_MHZ         = 250;
  localparam int DEGLITCH_NS     = 2000;
  localparam int DEGLITCH_CYC    = (DEGLITCH_NS * CLK_MHZ) / 1000;
  localparam int SLEEP_DELAY_US  = 200;
  localparam int SLEEP_DELAY_CYC = SLEEP_DELAY_US * CLK_MHZ;
  localparam int LATCH_DELAY_US  = 3000;
  localparam int LATCH_DELAY_CYC = LATCH_DELAY_US * CLK_MHZ;
  localparam int ACTIVE_WAIT_US  = 25000;
  localparam int ACTIVE_WAIT_CYC = ACTIVE_WAIT_US * CLK_MHZ;

  localparam int TMR_W = 24;
  localparam int DG_W  = 9;
  localparam logic [DG_W-1:0] DG_LAST = DG_W'(DEGLITCH_CYC - 1);

  // Register map, byte addresses on the AXI4-Lite slave.
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] REG_EVENTS = 4'h8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register: bit 0 requests a software shutdown.
  localparam int   CTRL_SHUT_BIT = 0;
  localparam logic CTRL_SHUT_RST = 1'b0;

  // Sticky event bits, cleared by writing one.
  localparam int EV_W       = 4;
  localparam int EV_FAULT   = 0;
  localparam int EV_REFUSED = 1;
  localparam int EV_SLEEP   = 2;
  localparam int EV_WAKE    = 3;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;

  typedef enum logic [3:0] {
    ST_OFF         = 4'h0,
    ST_RAMP        = 4'h1,
    ST_LATCH_WAIT  = 4'h2,
    ST_ACTIVE_WAIT = 4'h3,
    ST_ACTIVE      = 4'h4,
    ST_SLEEP_DELAY = 4'h5,
    ST_S3          = 4'h6,
    ST_S5          = 4'h7,
    ST_SHUTDOWN    = 4'h8,
    ST_LATCHOFF    = 4'h9
  } asps_state_t;

  // Comparator and pin levels, all asynchronous to aclk.
  typedef struct packed {
    logic sleep3_request_n;
    logic sleep5_request_n;
    logic dual5_sleep_support_en;
    logic mem_sel_low;
    logic mem_sel_high;
    logic bias_por_ok;
    logic soft_start_low;
    logic dual33_ramp_done;
    logic atx33_ok;
    logic atx5_ok;
    logic atx12_ok;
    logic dual5_uv;
    logic mem33_uv;
    logic mem25_uv;
    logic dual33_uv;
    logic clk_uv;
    logic overtemp;
  } asps_mon_t;

  typedef struct packed {
    logic dual33_standby_drive;
    logic active_switch_gate_drive;
    logic dual5_standby_switch_drive;
    logic mem25_external_drive;
    logic mem25_internal_en;
    logic mem33_internal_en;
    logic clock_chip_regulator_out;
    logic fault;
  } asps_drv_t;

endpackage

// ===== core/asps_core.sv
// Sleep-state power sequencer core with an AXI4-Lite register slave.
//
// Operation
// - Sleep inputs select active, S3 or S5.
// - Sleep inputs ignore pulses up to 2 us.
// - No direct move between S3 and S5.
// - Only active to sleep and back allowed.
// - Dual 5V on when active or enabled.
// - Support enable matters only in sleep states.
// - Enable changes during sleep are ignored.
// - Latch enable on sleep, start-up, shutdown exit.
// - Memory select picks 2.5V, 3.3V or both.
// - Bias reset release starts standby rail.
// - Latch selections 3 ms after standby ramp.
// - Clock regulator only in active state.
// - Active state asserts shared gate drive.
// - Sleep with support drives standby switch.
// - 2.5V memory internal asleep, external awake.
// - 3.3V memory internal asleep, switch awake.
// - Dual 3.3V NPN asleep, monitored once its ramp is done.
// - Fault high on undervoltage or overtemperature.
// - Soft-start low shuts down, fault low.
// - Wait 200 us before choosing S3/S5.
// - Wake waits 25 ms after ATX good.
// - Internal regulator fault shuts only itself.
`timescale 1ns/1ns
`default_nettype none

module asps_core
  import asps_pkg::*;
#(
  parameter logic [TMR_W-1:0] SLEEP_DELAY = TMR_W'(SLEEP_DELAY_CYC),
  parameter logic [TMR_W-1:0] LATCH_DELAY = TMR_W'(LATCH_DELAY_CYC),
  parameter logic [TMR_W-1:0] ACTIVE_WAIT = TMR_W'(ACTIVE_WAIT_CYC)
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire asps_mon_t         mon,
  output var  asps_drv_t         drv,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  asps_mon_t         mon_s1_r;
  asps_mon_t         m;
  wire logic [1:0]   raw_req;
  wire logic [1:0]   filt;
  logic              s3f;
  logic              s5f;
  asps_state_t       st_r;
  asps_state_t       st_nxt;
  logic [TMR_W-1:0]  tmr_r;
  logic              latch_now;
  logic              refused;
  logic              shut;
  logic              atx_ok;
  logic              act;
  logic              sleep_st;
  logic              powered;
  logic              uv_hit;
  logic              en_lat_r;
  logic              mem25_sel_r;
  logic              mem33_sel_r;
  logic              mem25_off_r;
  logic              mem33_off_r;
  logic              clk_off_r;
  asps_drv_t         drv_nxt;
  logic              ctrl_shut_r;
  logic [EV_W-1:0]   ev_r;
  logic [EV_W-1:0]   ev_set;
  logic [EV_W-1:0]   ev_clr;
  logic              aw_have_r;
  logic              w_have_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              do_write;
  logic [AXI_AW-1:0] wa;
  logic [AXI_AW-1:0] ra;

  // Two-stage synchroniser on every comparator and pin level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_s1_r <= '0;
      m        <= '0;
    end else begin
      mon_s1_r <= mon;
      m        <= mon_s1_r;
    end
  end

  assign raw_req = {m.sleep5_request_n, m.sleep3_request_n};

  // A new level is accepted only after it has held for the whole window.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dg
      logic            f_r;
      logic [DG_W-1:0] cnt_r;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          f_r   <= 1'b1;
          cnt_r <= '0;
        end else if (raw_req[gi] == f_r) begin
          cnt_r <= '0;
        end else if (cnt_r == DG_LAST) begin
          f_r   <= raw_req[gi];
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
      assign filt[gi] = f_r;
    end
  endgenerate

  always_comb begin
    s3f      = filt[0];
    s5f      = filt[1];
    shut     = m.soft_start_low | ctrl_shut_r;
    atx_ok   = m.atx33_ok & m.atx5_ok & m.atx12_ok;
    act      = (st_r == ST_ACTIVE) | (st_r == ST_SLEEP_DELAY);
    sleep_st = (st_r == ST_S3) | (st_r == ST_S5);
    powered  = (st_r != ST_OFF) & (st_r != ST_SHUTDOWN) &
               (st_r != ST_LATCHOFF);
  end

  // Operating state. Bias loss overrides every other state, shutdown every state but ST_LATCHOFF.
  always_comb begin
    st_nxt    = st_r;
    latch_now = 1'b0;
    refused   = 1'b0;
    if (!m.bias_por_ok) begin
      st_nxt = ST_OFF;
    end else if (shut && st_r != ST_LATCHOFF) begin
      st_nxt = ST_SHUTDOWN;
    end else begin
      case (st_r)
        ST_OFF: begin
          st_nxt = ST_RAMP;
        end
        ST_SHUTDOWN: begin
          st_nxt    = ST_RAMP;
          latch_now = 1'b1;
        end
        ST_RAMP: begin
          if (m.dual33_ramp_done) begin
            st_nxt = ST_LATCH_WAIT;
          end
        end
        ST_LATCH_WAIT: begin
          // Standby undervoltage before the other rails exist latches off.
          if (m.dual33_uv) begin
            st_nxt = ST_LATCHOFF;
          end else if (tmr_r == LATCH_DELAY - 1'b1) begin
            latch_now = 1'b1;
            if (s3f) begin
              st_nxt = ST_ACTIVE_WAIT;
            end else begin
              st_nxt = s5f ? ST_S3 : ST_S5;
            end
          end
        end
        ST_ACTIVE_WAIT: begin
          if (!s3f) begin
            st_nxt = ST_SLEEP_DELAY;
          end else if (tmr_r == ACTIVE_WAIT - 1'b1) begin
            st_nxt = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (!s3f) begin
            st_nxt = ST_SLEEP_DELAY;
          end
        end
        ST_SLEEP_DELAY: begin
          if (s3f) begin
            st_nxt = ST_ACTIVE;
          end else if (tmr_r == SLEEP_DELAY - 1'b1) begin
            latch_now = 1'b1;
            st_nxt    = s5f ? ST_S3 : ST_S5;
          end
        end
        ST_S3: begin
          if (s3f && s5f) begin
            st_nxt = ST_ACTIVE_WAIT;
          end else if (!s5f) begin
            refused = 1'b1;
          end
        end
        ST_S5: begin
          if (s3f && s5f) begin
            st_nxt = ST_ACTIVE_WAIT;
          end else if (s5f) begin
            refused = 1'b1;
          end
        end
        ST_LATCHOFF: begin
          st_nxt = ST_LATCHOFF;
        end
        default: begin
          st_nxt = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // One timer serves every timed state and restarts on each state change.
  // The wake timer also restarts whenever an ATX input drops out.
  always_ff @(posedge aclk) begin
    if (!aresetn || st_nxt != st_r) begin
      tmr_r <= '0;
    end else if (st_r == ST_ACTIVE_WAIT && !atx_ok) begin
      tmr_r <= '0;
    end else if (tmr_r != {TMR_W{1'b1}}) begin
      tmr_r <= tmr_r + 1'b1;
    end
  end

  // Selections are sampled only at latch points, so sleep-time changes
  // of the enable pin cannot reach the rails.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_lat_r    <= 1'b0;
      mem25_sel_r <= 1'b0;
      mem33_sel_r <= 1'b0;
    end else if (latch_now) begin
      en_lat_r    <= m.dual5_sleep_support_en;
      mem25_sel_r <= ~m.mem_sel_high;
      mem33_sel_r <= ~m.mem_sel_low;
    end
  end

  // Internal pass elements trip off on their own undervoltage and come
  // back only after a shutdown or loss of bias.
  always_ff @(posedge aclk) begin
    if (!aresetn || shut || !m.bias_por_ok) begin
      mem25_off_r <= 1'b0;
      mem33_off_r <= 1'b0;
      clk_off_r   <= 1'b0;
    end else begin
      mem25_off_r <= mem25_off_r | (drv.mem25_internal_en & m.mem25_uv);
      mem33_off_r <= mem33_off_r | (drv.mem33_internal_en & m.mem33_uv);
      clk_off_r   <= clk_off_r |
                     (drv.clock_chip_regulator_out & m.clk_uv);
    end
  end

  // Monitors count only while their rail is meant to be up.
  always_comb begin
    uv_hit = (m.dual5_uv & (act | (sleep_st & en_lat_r))) |
             (m.mem33_uv & (act | (sleep_st & mem33_sel_r))) |
             (m.mem25_uv & mem25_sel_r & (act | sleep_st)) |
             (m.dual33_uv & powered & (st_r != ST_RAMP)) |
             (m.clk_uv & drv.clock_chip_regulator_out) |
             (act & ~atx_ok) |
             m.overtemp;
  end

  always_comb begin
    drv_nxt.dual33_standby_drive       = powered & ~act;
    drv_nxt.active_switch_gate_drive   = act;
    drv_nxt.dual5_standby_switch_drive = sleep_st & en_lat_r;
    drv_nxt.mem25_external_drive       = act & mem25_sel_r;
    drv_nxt.mem25_internal_en          = sleep_st & mem25_sel_r &
                                         ~mem25_off_r;
    drv_nxt.mem33_internal_en          = sleep_st & mem33_sel_r &
                                         ~mem33_off_r;
    drv_nxt.clock_chip_regulator_out   = act & ~clk_off_r;
    drv_nxt.fault = ~shut & m.bias_por_ok &
                    (uv_hit | (st_r == ST_LATCHOFF));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv <= '0;
    end else begin
      drv <= drv_nxt;
    end
  end

  // Register slave. Address and data are taken in either order and the
  // response goes out once both are held.
  always_comb begin
    do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
    wa       = {awaddr_r[AXI_AW-1:2], 2'b00};
    ra       = {s_axi_araddr[AXI_AW-1:2], 2'b00};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_have_r     <= 1'b0;
      awaddr_r      <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_have_r     <= 1'b1;
      awaddr_r      <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_have_r     <= 1'b0;
    end else if (!aw_have_r && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_have_r     <= 1'b0;
      wdata_r      <= '0;
      wstrb_r      <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_have_r     <= 1'b1;
      wdata_r      <= s_axi_wdata;
      wstrb_r      <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_have_r     <= 1'b0;
    end else if (!w_have_r && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (wa == REG_CTRL || wa == REG_STATUS || wa == REG_EVENTS) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_shut_r <= CTRL_SHUT_RST;
    end else if (do_write && wa == REG_CTRL && wstrb_r[0]) begin
      ctrl_shut_r <= wdata_r[CTRL_SHUT_BIT];
    end
  end

  always_comb begin
    ev_set             = '0;
    ev_set[EV_FAULT]   = drv_nxt.fault & ~drv.fault;
    ev_set[EV_REFUSED] = refused;
    ev_set[EV_SLEEP]   = (st_nxt == ST_S3 || st_nxt == ST_S5) & ~sleep_st;
    ev_set[EV_WAKE]    = (st_nxt == ST_ACTIVE) & (st_r != ST_ACTIVE);
    ev_clr             = '0;
    if (do_write && wa == REG_EVENTS && wstrb_r[0]) begin
      ev_clr = wdata_r[EV_W-1:0];
    end
  end

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_r <= EV_RST;
    end else begin
      ev_r <= (ev_r & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      if (ra == REG_CTRL) begin
        s_axi_rdata <= {31'h0, ctrl_shut_r};
      end else if (ra == REG_STATUS) begin
        s_axi_rdata <= {19'h0, s5f, s3f, clk_off_r, mem33_off_r,
                        mem25_off_r, drv.fault, mem33_sel_r,
                        mem25_sel_r, en_lat_r, st_r};
      end else if (ra == REG_EVENTS) begin
        s_axi_rdata <= {28'h0, ev_r};
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  deglitch_window_a: assert property (
    $changed(filt[0]) |-> $past(g_dg[0].cnt_r) == DG_LAST
  ) else $error("sleep3 filter changed before its window ended");

  no_cross_sleep_a: assert property (
    (st_r == ST_S5) |-> ($past(st_r) != ST_S3)
  ) else $error("direct move from S3 to S5");

  sleep_entry_delay_a: assert property (
    (sleep_st && $past(st_r) == ST_SLEEP_DELAY) |->
      $past(tmr_r) == SLEEP_DELAY - 1'b1
  ) else $error("sleep entered before the delay ran out");

  wake_wait_a: assert property (
    (st_r == ST_ACTIVE && $past(st_r) == ST_ACTIVE_WAIT) |->
      $past(tmr_r) == ACTIVE_WAIT - 1'b1
  ) else $error("active entered before the wake wait ran out");

  latch_delay_a: assert property (
    ($past(st_r) == ST_LATCH_WAIT && st_r != ST_LATCH_WAIT &&
     st_r != ST_LATCHOFF && $past(m.bias_por_ok) && !$past(shut)) |->
      $past(tmr_r) == LATCH_DELAY - 1'b1
  ) else $error("start-up latch before the delay ran out");

  enable_hold_a: assert property (
    ($past(sleep_st) && sleep_st) |-> $stable(en_lat_r)
  ) else $error("support enable changed during sleep");

  clk_active_a: assert property (
    drv.clock_chip_regulator_out |-> $past(act)
  ) else $error("clock regulator on outside active state");

  dual5_sleep_a: assert property (
    $past(sleep_st && !en_lat_r) |->
      !drv.dual5_standby_switch_drive && !drv.active_switch_gate_drive
  ) else $error("dual 5V powered in sleep without support");

  standby_switch_a: assert property (
    $past(sleep_st && en_lat_r) |-> drv.dual5_standby_switch_drive
  ) else $error("standby switch off in supported sleep");

  mem_select_a: assert property (
    (drv.mem25_internal_en |-> $past(mem25_sel_r)) and
    (drv.mem33_internal_en |-> $past(mem33_sel_r))
  ) else $error("memory rail on against its selection");

  pass_tripoff_a: assert property (
    $past(mem25_off_r) |-> !drv.mem25_internal_en
  ) else $error("tripped 2.5V memory regulator still on");

  shutdown_fault_a: assert property (
    $past(shut) |-> !drv.fault ##1 !drv.active_switch_gate_drive
  ) else $error("fault or gate drive left on in shutdown");

  overtemp_fault_a: assert property (
    $past(m.overtemp && !shut && m.bias_por_ok) |-> drv.fault
  ) else $error("overtemperature did not raise fault");

endmodule

`default_nettype wire

// ===== dv/asps_supply_model.sv
// Model of the bias supply, the supply rails and the sleep-state chipset.
`timescale 1ns/1ns
`default_nettype none
module asps_supply_model (
  input  wire logic       aclk,
  input  wire logic       bias_on,
  input  wire logic       atx_on,
  input  wire logic [1:0] sleep_cmd,
  input  wire logic [7:0] lag,
  output logic            bias_por_ok,
  output logic            ramp_done,
  output logic            atx_ok,
  output logic            sleep3_request_n,
  output logic            sleep5_request_n
);
  logic [7:0] ramp_cnt;
  logic [7:0] atx_cnt;
  // Command 3 holds only the deeper request, a combination a well-behaved
  // chipset never settles on; the bench uses it as a short glitch.
  assign sleep3_request_n = (sleep_cmd != 2'h1) &&
                            (sleep_cmd != 2'h2);
  assign sleep5_request_n = !sleep_cmd[1];
  // A larger lag stands for a slow standby ramp and slow supply rails.
  always_ff @(posedge aclk) begin
    bias_por_ok <= bias_on;
    ramp_cnt    <= !bias_on ? 8'h00 : ramp_cnt + {7'h00, ramp_cnt != lag};
    ramp_done   <= bias_on && ramp_cnt == lag;
  end
  always_ff @(posedge aclk) begin
    atx_cnt <= !atx_on ? 8'h00 : atx_cnt + {7'h00, atx_cnt != lag};
    atx_ok  <= atx_on && atx_cnt == lag;
  end
endmodule
`default_nettype wire

// ===== dv/asps_core_tb.sv
// Self-checking bench for the sleep-state sequencer core.
`timescale 1ns/1ns
`default_nettype none
module asps_core_tb;
  import asps_pkg::*;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  asps_mon_t   mon;
  asps_drv_t   drv;
  logic [3:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic        awv, wv, bv, br, arv, rv, rr, awr, wr_r, arr;
  logic [1:0]  bresp, rresp, cmd;
  logic [7:0]  lag;
  logic        bias_on, atx_on, por_ok, ramp_done, atx_ok;
  logic        sleep3_request_n, sleep5_request_n;
  logic        en, msl, msh, ssl, ot, m25uv, d33uv;
  int          num_errors = 0;
  int          checks = 0;
  logic [31:0] seed = 32'hECCE60CE;

  assign mon = {sleep3_request_n, sleep5_request_n, en, msl, msh, por_ok,
                ssl, ramp_done, {3{atx_ok}}, 2'h0, m25uv, d33uv, 1'b0, ot};
  always #2 aclk = ~aclk;

  asps_supply_model sup (.aclk(aclk), .bias_on(bias_on), .atx_on(atx_on),
    .sleep_cmd(cmd), .lag(lag), .bias_por_ok(por_ok),
    .ramp_done(ramp_done), .atx_ok(atx_ok),
    .sleep3_request_n(sleep3_request_n), .sleep5_request_n(sleep5_request_n));
  asps_core #(.SLEEP_DELAY(24'h000014), .LATCH_DELAY(24'h000028),
    .ACTIVE_WAIT(24'h00003C)) dut (.aclk(aclk), .aresetn(aresetn),
    .mon(mon), .drv(drv), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic asps_drv_t exp_drv(input logic slp, en, m25, m33);
    asps_drv_t e;
    e = '0;
    e.active_switch_gate_drive   = !slp;
    e.clock_chip_regulator_out   = !slp;
    e.mem25_external_drive       = !slp && m25;
    e.mem25_internal_en          = slp && m25;
    e.mem33_internal_en          = slp && m33;
    e.dual33_standby_drive       = slp;
    e.dual5_standby_switch_drive = slp && en;
    return e;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    do @(posedge aclk); while (!rv);
    d = rdat;
    r = rresp;
    rr <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_ok = 1'b0;
    logic w_ok  = 1'b0;
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      aw_ok |= awr;
      w_ok  |= wr_r;
      awv <= !aw_ok;
      wv  <= !w_ok;
    end
    do @(posedge aclk); while (!bv);
    r = bresp;
    br <= 1'b0;
    @(posedge aclk);
  endtask
  // Polls the state field; a bounded poll keeps a stuck design from hanging.
  task automatic wait_st(input asps_state_t st);
    logic [31:0] d;
    logic [1:0]  r;
    repeat (500) begin
      rd(REG_STATUS, d, r);
      if (d[3:0] === st) break;
    end
    chk(d[3:0], st);
  endtask
  task automatic end_sim();
    $display("checks %0d, num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    end_sim();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          k;
    {awv, wv, br, arv, rr, awa, ara, wd} = '0;
    {bias_on, atx_on, en, msl, msh, ssl, ot, m25uv, d33uv} = 9'h040;
    cmd = 2'h0;
    lag = 8'h03;
    cyc(6);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(drv, 32'h0);
    rd(4'hC, d, r);
    chk(r, RESP_SLVERR);
    bias_on <= 1'b1;
    atx_on  <= 1'b1;
    wait_st(ST_ACTIVE_WAIT);
    chk(drv.active_switch_gate_drive, 1'b0);
    wait_st(ST_ACTIVE);
    chk(drv, exp_drv(1'b0, 1'b1, 1'b1, 1'b1));
    $display("power-up test done");
    for (int i = 0; i < 6; i++) begin
      k = 1 + int'(xs() % 32'd450);
      cmd <= 2'(1 + xs() % 3);
      cyc(k);
      cmd <= 2'h0;
      cyc(600);
    end
    rd(REG_EVENTS, d, r);
    chk(d[2], 1'b0);
    wait_st(ST_ACTIVE);
    $display("deglitch test done");
    for (int m = 0; m < 3; m++) begin
      k = int'(xs() & 32'h1);
      en  <= k[0];
      msl <= m == 1;
      msh <= m == 2;
      cyc(4);
      cmd <= m[0] ? 2'h2 : 2'h1;
      wait_st(m[0] ? ST_S5 : ST_S3);
      chk(drv, exp_drv(1'b1, k[0], m != 2, m != 1));
      cmd <= 2'h0;
      wait_st(ST_ACTIVE);
      chk(drv, exp_drv(1'b0, k[0], m != 2, m != 1));
    end
    $display("sleep state test done");
    en  <= 1'b1;
    msl <= 1'b0;
    msh <= 1'b0;
    cyc(4);
    cmd <= 2'h1;
    wait_st(ST_S3);
    en  <= 1'b0;
    cmd <= 2'h2;
    cyc(700);
    rd(REG_STATUS, d, r);
    chk(d[3:0], ST_S3);
    chk(drv.dual5_standby_switch_drive, 1'b1);
    rd(REG_EVENTS, d, r);
    chk(d[1], 1'b1);
    m25uv <= 1'b1;
    cyc(10);
    chk({drv.fault, drv.mem25_internal_en, drv.mem33_internal_en}, 3'h5);
    m25uv <= 1'b0;
    ot    <= 1'b1;
    cyc(8);
    chk(drv.fault, 1'b1);
    $display("refusal test done");
    ssl <= 1'b1;
    cmd <= 2'h0;
    wait_st(ST_SHUTDOWN);
    chk(drv, 32'h0);
    cyc(600);
    ssl <= 1'b0;
    ot  <= 1'b0;
    lag <= 8'(xs());
    wait_st(ST_ACTIVE);
    $display("shutdown test done");
    wr(REG_CTRL, 32'h1, r);
    chk(r, RESP_OKAY);
    wait_st(ST_SHUTDOWN);
    rd(REG_CTRL, d, r);
    chk(d, 32'h1);
    wr(REG_CTRL, 32'h0, r);
    wait_st(ST_ACTIVE);
    wr(4'hC, 32'h1, r);
    chk(r, RESP_SLVERR);
    wr(REG_STATUS, 32'hF, r);
    chk(r, RESP_OKAY);
    wr(REG_EVENTS, 32'hF, r);
    rd(REG_EVENTS, d, r);
    chk(d, 32'h0);
    $display("register test done");
    // Standby undervoltage before the other rails are up must latch off.
    bias_on <= 1'b0;
    wait_st(ST_OFF);
    chk(drv, 32'h0);
    bias_on <= 1'b1;
    wait_st(ST_LATCH_WAIT);
    d33uv <= 1'b1;
    wait_st(ST_LATCHOFF);
    d33uv <= 1'b0;
    cyc(8);
    chk(drv.fault, 1'b1);
    chk(drv.active_switch_gate_drive, 1'b0);
    $display("latch-off test done");
    end_sim();
  end
endmodule
`default_nettype wire
